// ### core/abm_master.sv
`timescale 1ns/1ps

// How it works
// - Two-state grant tracker on rising edge
// - Grant only when agnt high, wait low
// - Default master resets into granted state
// - Six-state main machine on falling edge
// - Core request high while bus needed
// - Core holds request until transfer done
// - Grant and request steer; grant alone in handover, retract
// - Latched responses decide leaving active
// - Default master resets main machine to busidle
// - Idle: address-only, clock on, all tristate
// - Busidle: core type, clock on, address by grant
// - Hold: address-only, clock off, all tristate
// - Handover: sequential, clock off, address by grant
// - Active: core type, clock by wait, writes drive
// - Retract: address-only, clock off, writes drive
// - Type drivers on while agnt and clock high
// - Address enable and data enable gate drivers
// - Nonsequential address valid in preceding high phase
// - Sequential write data from falling edge
// - Address-only drives early, or low phase handover
// - Address valid through high before sequential
module abm_master (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               agnt,
  input  wire abm_pkg::abm_resp_t resp,
  input  wire abm_pkg::abm_core_t core,
  output logic [1:0]              btran,
  output logic                    btran_oe,
  output logic                    addr_oe,
  output logic                    data_oe,
  output logic                    core_clk_en,
  output logic                    granted,
  output logic                    xfer_done,
  output logic                    xfer_error
);

  abm_pkg::abm_state_t state;
  abm_pkg::abm_state_t cur_state;
  abm_pkg::abm_state_t next_state;
  abm_pkg::abm_resp_t  resp_q;
  abm_pkg::abm_drive_t next_drive;
  logic                fresh_rise;
  logic                fresh_fall;
  logic                agnt_strap;
  logic                granted_eff;
  logic                next_granted;
  logic                oe_rise;
  logic                oe_fall;
  logic                resp_retract;
  logic                resp_finish;
  logic                next_done;
  logic                next_error;

  // Reset flops take constants; the default-master strap is caught by a clocked flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fresh_rise <= 1'b1;
    end else begin
      fresh_rise <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (fresh_rise) begin
      agnt_strap <= agnt;
    end
  end

  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      fresh_fall <= 1'b1;
    end else begin
      fresh_fall <= 1'b0;
    end
  end

  // Until the first edge after release the strap stands in for the state
  assign granted_eff = fresh_rise ? agnt_strap : granted;
  assign cur_state   = fresh_fall ?
                       (agnt_strap ? abm_pkg::ST_BUSIDLE : abm_pkg::ST_IDLE) :
                       state;

  always_comb begin
    next_granted = granted_eff;
    if (!resp.bwait) begin
      next_granted = agnt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      granted <= abm_pkg::RST_GRANTED;
    end else begin
      granted <= next_granted;
    end
  end

  // Responses are valid by the rising edge; hold them for the falling-edge machine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resp_q <= abm_pkg::RESP_RST;
    end else begin
      resp_q <= resp;
    end
  end

  assign resp_retract = resp_q.bwait && resp_q.berror && resp_q.blast;
  assign resp_finish  = !resp_q.bwait;

  // Type drivers: xor of a rising-edge and a falling-edge flop is high only in
  // the high phase that follows a rising edge with agnt high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oe_rise <= 1'b0;
    end else begin
      oe_rise <= oe_fall ^ agnt;
    end
  end

  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      oe_fall <= 1'b0;
    end else begin
      oe_fall <= oe_rise;
    end
  end

  assign btran_oe = oe_rise ^ oe_fall;

  // Core request must stay high until the transfer completes
  always_comb begin
    next_state = cur_state;
    case (cur_state)
      abm_pkg::ST_IDLE: begin
        if (core.request && granted_eff) begin
          next_state = abm_pkg::ST_HANDOVER;
        end else if (core.request) begin
          next_state = abm_pkg::ST_HOLD;
        end else if (granted_eff) begin
          next_state = abm_pkg::ST_BUSIDLE;
        end
      end
      abm_pkg::ST_BUSIDLE: begin
        if (core.request && granted_eff) begin
          next_state = abm_pkg::ST_ACTIVE;
        end else if (core.request) begin
          next_state = abm_pkg::ST_HOLD;
        end else if (!granted_eff) begin
          next_state = abm_pkg::ST_IDLE;
        end
      end
      abm_pkg::ST_HOLD: begin
        if (granted_eff) begin
          next_state = abm_pkg::ST_HANDOVER;
        end else if (!core.request) begin
          next_state = abm_pkg::ST_IDLE;
        end
      end
      abm_pkg::ST_HANDOVER: begin
        if (granted_eff) begin
          next_state = abm_pkg::ST_ACTIVE;
        end else begin
          next_state = abm_pkg::ST_HOLD;
        end
      end
      abm_pkg::ST_ACTIVE: begin
        if (resp_retract) begin
          next_state = abm_pkg::ST_RETRACT;
        end else if (!resp_finish) begin
          next_state = abm_pkg::ST_ACTIVE;
        end else if (core.request && granted_eff) begin
          next_state = abm_pkg::ST_ACTIVE;
        end else if (core.request) begin
          next_state = abm_pkg::ST_HOLD;
        end else if (granted_eff) begin
          next_state = abm_pkg::ST_BUSIDLE;
        end else begin
          next_state = abm_pkg::ST_IDLE;
        end
      end
      abm_pkg::ST_RETRACT: begin
        if (granted_eff) begin
          next_state = abm_pkg::ST_ACTIVE;
        end else begin
          next_state = abm_pkg::ST_HOLD;
        end
      end
      default: begin
        next_state = abm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      state <= abm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Drive actions for the state being entered, so they hold through the
  // whole cycle from the falling edge, covering the next high phase
  always_comb begin
    next_drive = abm_pkg::DRIVE_RST;
    case (next_state)
      abm_pkg::ST_IDLE: begin
        next_drive = abm_pkg::DRIVE_RST;
      end
      abm_pkg::ST_BUSIDLE: begin
        next_drive.btran   = core.trans;
        next_drive.clk_en  = 1'b1;
        next_drive.addr_oe = granted_eff;
        next_drive.data_oe = 1'b0;
      end
      abm_pkg::ST_HOLD: begin
        next_drive.btran   = abm_pkg::TRANS_ADDR_ONLY;
        next_drive.clk_en  = 1'b0;
        next_drive.addr_oe = 1'b0;
        next_drive.data_oe = 1'b0;
      end
      abm_pkg::ST_HANDOVER: begin
        next_drive.btran   = abm_pkg::TRANS_SEQ;
        next_drive.clk_en  = 1'b0;
        next_drive.addr_oe = granted_eff;
        next_drive.data_oe = 1'b0;
      end
      abm_pkg::ST_ACTIVE: begin
        next_drive.btran   = core.trans;
        next_drive.clk_en  = !resp_q.bwait;
        next_drive.addr_oe = granted_eff;
        next_drive.data_oe = core.write;
      end
      abm_pkg::ST_RETRACT: begin
        next_drive.btran   = abm_pkg::TRANS_ADDR_ONLY;
        next_drive.clk_en  = 1'b0;
        next_drive.addr_oe = granted_eff;
        next_drive.data_oe = core.write;
      end
      default: begin
        next_drive = abm_pkg::DRIVE_RST;
      end
    endcase
  end

  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      btran       <= abm_pkg::TRANS_ADDR_ONLY;
      core_clk_en <= abm_pkg::RST_CLK_EN;
      addr_oe     <= abm_pkg::RST_ADDR_OE;
      data_oe     <= abm_pkg::RST_DATA_OE;
    end else begin
      btran       <= next_drive.btran;
      core_clk_en <= next_drive.clk_en;
      addr_oe     <= next_drive.addr_oe;
      data_oe     <= next_drive.data_oe;
    end
  end

  // One-cycle completion pulse so the core knows when to drop its request
  assign next_done  = (cur_state == abm_pkg::ST_ACTIVE) && resp_finish;
  assign next_error = next_done && resp_q.berror && !resp_q.blast;

  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      xfer_done  <= 1'b0;
      xfer_error <= 1'b0;
    end else begin
      xfer_done  <= next_done;
      xfer_error <= next_error;
    end
  end

  sequence s_in_active;
    state == abm_pkg::ST_ACTIVE;
  endsequence

  sequence s_wait_seen;
    resp_q.bwait && !resp_retract;
  endsequence

  sequence s_retract_seen;
    resp_retract;
  endsequence

  property p_grant_needs_ready;
    @(posedge clk) disable iff (reset)
      !fresh_rise && !granted && resp.bwait |=> !granted;
  endproperty
  a_grant_needs_ready: assert property (p_grant_needs_ready)
    else $error("grant taken while wait high");

  property p_grant_taken;
    @(posedge clk) disable iff (reset)
      !fresh_rise && agnt && !resp.bwait |=> granted;
  endproperty
  a_grant_taken: assert property (p_grant_taken)
    else $error("grant not taken with agnt and wait low");

  property p_reset_grant;
    @(posedge clk) disable iff (reset)
      fresh_rise && resp.bwait |=> granted == $past(agnt_strap);
  endproperty
  a_reset_grant: assert property (p_reset_grant)
    else $error("grant tracker left reset in wrong state");

  property p_idle_drive;
    @(negedge clk) disable iff (reset)
      state == abm_pkg::ST_IDLE |->
        btran == abm_pkg::TRANS_ADDR_ONLY && core_clk_en && !addr_oe && !data_oe;
  endproperty
  a_idle_drive: assert property (p_idle_drive)
    else $error("idle drive actions wrong");

  property p_hold_drive;
    @(negedge clk) disable iff (reset)
      state == abm_pkg::ST_HOLD |->
        btran == abm_pkg::TRANS_ADDR_ONLY && !core_clk_en && !addr_oe && !data_oe;
  endproperty
  a_hold_drive: assert property (p_hold_drive)
    else $error("hold drive actions wrong");

  property p_handover_drive;
    @(negedge clk) disable iff (reset)
      state == abm_pkg::ST_HANDOVER |->
        btran == abm_pkg::TRANS_SEQ && !core_clk_en && !data_oe;
  endproperty
  a_handover_drive: assert property (p_handover_drive)
    else $error("handover drive actions wrong");

  property p_retract_drive;
    @(negedge clk) disable iff (reset)
      state == abm_pkg::ST_RETRACT |->
        btran == abm_pkg::TRANS_ADDR_ONLY && !core_clk_en;
  endproperty
  a_retract_drive: assert property (p_retract_drive)
    else $error("retract drive actions wrong");

  property p_wait_stays;
    @(negedge clk) disable iff (reset)
      s_in_active ##0 s_wait_seen |=> state == abm_pkg::ST_ACTIVE && !core_clk_en;
  endproperty
  a_wait_stays: assert property (p_wait_stays)
    else $error("active left on wait");

  property p_retract_entry;
    @(negedge clk) disable iff (reset)
      s_in_active ##0 s_retract_seen |=> state == abm_pkg::ST_RETRACT ##1
        (state == abm_pkg::ST_ACTIVE || state == abm_pkg::ST_HOLD);
  endproperty
  a_retract_entry: assert property (p_retract_entry)
    else $error("retract response not followed");

  property p_done_pulse;
    @(negedge clk) disable iff (reset)
      s_in_active ##0 !resp_q.bwait |=> xfer_done ##1
        (!xfer_done || $past(state) == abm_pkg::ST_ACTIVE);
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion not reported");

  property p_type_oe_low_phase;
    @(posedge clk) disable iff (reset)
      1'b1 |-> !btran_oe;
  endproperty
  a_type_oe_low_phase: assert property (p_type_oe_low_phase)
    else $error("type drivers on in low phase");

endmodule

// ### core/abm_pkg.sv
package abm_pkg;

  // Bus transfer type driven on the shared transfer-type lines
  localparam int         TRANS_W         = 2;
  localparam logic [1:0] TRANS_ADDR_ONLY = 2'h0;
  localparam logic [1:0] TRANS_RESERVED  = 2'h1;
  localparam logic [1:0] TRANS_NONSEQ    = 2'h2;
  localparam logic [1:0] TRANS_SEQ       = 2'h3;

  // Reset values of the registered outputs
  localparam logic       RST_CLK_EN  = 1'b1;
  localparam logic       RST_ADDR_OE = 1'b0;
  localparam logic       RST_DATA_OE = 1'b0;
  localparam logic       RST_GRANTED = 1'b0;

  // Transfer response as sampled from the wait, error and last lines
  typedef struct packed {
    logic bwait;
    logic berror;
    logic blast;
  } abm_resp_t;

  localparam abm_resp_t RESP_RST = '{bwait: 1'b0, berror: 1'b0, blast: 1'b0};

  // Master core side of the interface
  typedef struct packed {
    logic                     request;
    logic                     write;
    logic [TRANS_W-1:0]       trans;
  } abm_core_t;

  // Main bus interface states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_BUSIDLE  = 3'h1,
    ST_HOLD     = 3'h2,
    ST_HANDOVER = 3'h3,
    ST_ACTIVE   = 3'h4,
    ST_RETRACT  = 3'h5
  } abm_state_t;

  // Outputs that the main machine registers on the falling edge
  typedef struct packed {
    logic [TRANS_W-1:0] btran;
    logic               clk_en;
    logic               addr_oe;
    logic               data_oe;
  } abm_drive_t;

  localparam abm_drive_t DRIVE_RST = '{btran:   TRANS_ADDR_ONLY,
                                       clk_en:  RST_CLK_EN,
                                       addr_oe: RST_ADDR_OE,
                                       data_oe: RST_DATA_OE};

endpackage

// ### dv/abm_resp_model.sv
`timescale 1ns/1ps

// Arbiter grant and slave/decoder response as seen by the master.
// The response code is encoded onto the wait, error and last lines.
module abm_resp_model (
  input  wire logic          give,
  input  wire logic [2:0]    kind,
  output logic               agnt,
  output abm_pkg::abm_resp_t resp
);

  assign agnt = give;

  // 0 done, 1 last, 2 error, 3 wait, 4 retract
  always_comb begin
    case (kind)
      3'h1: begin
        resp = '{bwait: 1'b0, berror: 1'b0, blast: 1'b1};
      end
      3'h2: begin
        resp = '{bwait: 1'b0, berror: 1'b1, blast: 1'b0};
      end
      3'h3: begin
        resp = '{bwait: 1'b1, berror: 1'b0, blast: 1'b0};
      end
      3'h4: begin
        resp = '{bwait: 1'b1, berror: 1'b1, blast: 1'b1};
      end
      default: begin
        resp = '{bwait: 1'b0, berror: 1'b0, blast: 1'b0};
      end
    endcase
  end

endmodule

// ### dv/abm_master_tb.sv
`timescale 1ns/1ps

module abm_master_tb;

  localparam logic [2:0] K_DONE = 3'h0;
  localparam logic [2:0] K_LAST = 3'h1;
  localparam logic [2:0] K_ERR  = 3'h2;
  localparam logic [2:0] K_WAIT = 3'h3;
  localparam logic [2:0] K_RETR = 3'h4;

  // Per cycle: grant, response, request, expected
  // {btran[1:0], core_clk_en, addr_oe, data_oe, xfer_done, xfer_error, granted}
  typedef struct packed {
    logic       g;
    logic [2:0] k;
    logic       r;
    logic [7:0] e;
  } abm_row_t;

  localparam int NROWS = 16;
  localparam abm_row_t ROWS [NROWS] = '{
    '{1'b1, K_WAIT, 1'b0, 8'h20},
    '{1'b1, K_WAIT, 1'b0, 8'h20},
    '{1'b1, K_DONE, 1'b0, 8'hb1},
    '{1'b1, K_DONE, 1'b1, 8'hb9},
    '{1'b1, K_WAIT, 1'b1, 8'h99},
    '{1'b1, K_DONE, 1'b1, 8'hbd},
    '{1'b1, K_RETR, 1'b1, 8'h19},
    '{1'b1, K_DONE, 1'b1, 8'hb9},
    '{1'b1, K_ERR,  1'b1, 8'hbf},
    '{1'b1, K_LAST, 1'b0, 8'hb5},
    '{1'b0, K_DONE, 1'b0, 8'h20},
    '{1'b0, K_DONE, 1'b1, 8'h00},
    '{1'b1, K_DONE, 1'b1, 8'hd1},
    '{1'b1, K_DONE, 1'b1, 8'hb9},
    '{1'b1, K_DONE, 1'b1, 8'hbd},
    '{1'b1, K_DONE, 1'b0, 8'hb5}
  };

  logic               clk;
  logic               reset;
  logic               give;
  logic [2:0]         kind;
  logic               agnt;
  abm_pkg::abm_resp_t resp;
  abm_pkg::abm_core_t core;
  logic [1:0]         btran;
  logic               btran_oe;
  logic               addr_oe;
  logic               data_oe;
  logic               core_clk_en;
  logic               granted;
  logic               xfer_done;
  logic               xfer_error;
  logic [7:0]         obs;
  int                 n_errors;
  int                 check_count;

  assign obs = {btran, core_clk_en, addr_oe, data_oe, xfer_done, xfer_error, granted};

  abm_resp_model i_far (
    .give (give),
    .kind (kind),
    .agnt (agnt),
    .resp (resp)
  );

  abm_master i_dut (
    .clk         (clk),
    .reset       (reset),
    .agnt        (agnt),
    .resp        (resp),
    .core        (core),
    .btran       (btran),
    .btran_oe    (btran_oe),
    .addr_oe     (addr_oe),
    .data_oe     (data_oe),
    .core_clk_en (core_clk_en),
    .granted     (granted),
    .xfer_done   (xfer_done),
    .xfer_error  (xfer_error)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rise();
    @(posedge clk);
    #1;
  endtask

  task automatic fall();
    @(negedge clk);
    #1;
  endtask

  // Reset with or without the default-master strap, then settled state
  task automatic do_reset(input logic strap);
    reset = 1'b1;
    give = strap;
    // Wait held through release so only the strap can set the grant
    kind = K_WAIT;
    core.request = 1'b0;
    repeat (3) rise();
    chk(obs, 8'h20);
    chk(8'(btran_oe), 8'h00);
    reset = 1'b0;
    rise();
    chk(8'(granted), 8'(strap));
    fall();
    rise();
    fall();
    chk(obs, strap ? 8'hb1 : 8'h20);
  endtask

  // One row per cycle; the outcome of a row shows after the next falling edge
  task automatic run_table();
    for (int i = 0; i <= NROWS; i++) begin
      rise();
      chk(8'(btran_oe), 8'(give));
      if (i < NROWS) begin
        give = ROWS[i].g;
        kind = ROWS[i].k;
      end
      if (i > 0) begin
        core.request = ROWS[i-1].r;
      end
      fall();
      chk(8'(btran_oe), 8'h00);
      if (i > 0) begin
        chk(obs, ROWS[i-1].e);
      end
    end
  endtask

  // Sequential read from the default master: core type on the bus, data off
  task automatic read_seq();
    rise();
    chk(8'(btran_oe), 8'h01);
    core.write   = 1'b0;
    core.trans   = abm_pkg::TRANS_SEQ;
    kind         = K_DONE;
    core.request = 1'b1;
    fall();
    chk(obs, 8'hd1);
    rise();
    core.request = 1'b0;
    fall();
    chk(obs, 8'hf5);
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    core.write = 1'b1;
    core.trans = abm_pkg::TRANS_NONSEQ;
    do_reset(1'b0);
    run_table();
    do_reset(1'b1);
    read_seq();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    test_done();
  end

endmodule
